// >>> rtl/descriptor_dma_sequencer.sv
// Descriptor DMA sequencer: AXI4-Lite settings and a ring descriptor bus master.
`timescale 1ns/10ps
`include "dsq_consts.svh"

module descriptor_dma_sequencer (
    input  wire logic        mclk,
    input  wire logic        rst,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Descriptor requests from the microcode
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic        cmd_chain_mid,
    input  wire logic [31:0] cmd_base,
    input  wire logic [31:0] cmd_status_dword,
    input  wire logic [15:0] cmd_status_word,
    output logic             cmd_done,
    output logic [31:0]      descriptor_word_zero,
    output logic [31:0]      descriptor_word_one,
    output logic [31:0]      descriptor_word_two,
    // Master bus pins
    output logic             req_n,
    input  wire logic        gnt_n,
    output logic             frame_n,
    output logic             irdy_n,
    output logic             ctl_oe,
    input  wire logic        trdy_n,
    output logic [3:0]       cbe_n,
    output logic [31:0]      ad_out,
    output logic             ad_oe,
    input  wire logic [31:0] ad_in
);

    logic [7:0]  software_structure_style;
    logic        burst_read_enable;
    logic        burst_write_enable;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        have_aw;
    logic        have_w;

    dsq_pkg::seq_state_e state;
    logic [7:0]  style_q;
    logic        burst_q;
    logic        write_q;
    logic        mid_q;
    logic [31:0] base_q;
    logic [31:0] sdw_q;
    logic [15:0] sw_q;
    logic        idx;
    logic        last_idx;
    logic [31:0] rd_a;
    logic        gnt_s;
    logic        trdy_s;
    logic [31:0] ad_s;
    logic [31:0] next_addr;
    logic [3:0]  next_be;
    logic [31:0] next_wdata;
    logic        style16;
    logic        style_burst;

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    // Every pin is retimed, which costs two clocks of reaction to TRDY.
    pin_sync #(.W(34)) u_sync (
        .mclk    (mclk),
        .rst     (rst),
        .d       ({gnt_n, trdy_n, ad_in}),
        .rst_val ({2'h3, 32'h0000_0000}),
        .q       ({gnt_s, trdy_s, ad_s})
    );

    // ======================================================================
    // AXI4-Lite write channel
    // ======================================================================
    // Address and data are taken in either order; the response follows both.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_awready      <= 1'b1;
            s_axi_wready       <= 1'b1;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= `DSQ_RESP_OKAY;
            have_aw            <= 1'b0;
            have_w             <= 1'b0;
            wr_addr            <= 4'h0;
            wr_data            <= 32'h0000_0000;
            wr_strb            <= 4'h0;
            software_structure_style <= `DSQ_RST_STYLE;
            burst_read_enable  <= `DSQ_RST_BURST_READ;
            burst_write_enable <= `DSQ_RST_BURST_WRITE;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr       <= s_axi_awaddr;
                have_aw       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                have_w       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (have_aw && have_w && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `DSQ_RESP_OKAY;
                case ({wr_addr[3:2], 2'b00})
                    `DSQ_OFF_STYLE: begin
                        if (wr_strb[0]) begin
                            software_structure_style <= wr_data[7:0];
                        end
                    end
                    `DSQ_OFF_BURST: begin
                        if (wr_strb[0]) begin
                            burst_read_enable  <= wr_data[`DSQ_BIT_BURST_READ];
                            burst_write_enable <= wr_data[`DSQ_BIT_BURST_WRITE];
                        end
                    end
                    `DSQ_OFF_STATUS: begin // Read-only: the write is ignored.
                    end
                    default: begin
                        s_axi_bresp <= `DSQ_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                have_aw       <= 1'b0;
                have_w        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ======================================================================
    // AXI4-Lite read channel
    // ======================================================================
    // The status word shows the sequencer state and whether it is busy.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DSQ_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `DSQ_RESP_OKAY;
                case ({s_axi_araddr[3:2], 2'b00})
                    `DSQ_OFF_STYLE:  s_axi_rdata <= {24'h00_0000, software_structure_style};
                    `DSQ_OFF_BURST:  s_axi_rdata <= {25'h000_0000, burst_read_enable,
                                                     burst_write_enable, 5'h00};
                    `DSQ_OFF_STATUS: s_axi_rdata <= {27'h000_0000, write_q, !cmd_ready,
                                                     state};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `DSQ_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Transfer shape of the current phase
    // ======================================================================
    // Styles other than 0 and 3 behave like style 2.
    assign style16     = (style_q == `DSQ_STYLE_16);
    assign style_burst = (style_q == `DSQ_STYLE_32_BURST);

    always_comb begin
        next_addr  = cmd_base;
        next_be    = `DSQ_BE_ALL;
        next_wdata = 32'h0000_0000;
        if (!write_q) begin
            if (style_burst) begin
                next_addr = base_q + (idx ? `DSQ_DOFF_08 : `DSQ_DOFF_04);
            end else begin
                next_addr = base_q + (idx ? `DSQ_DOFF_04 : `DSQ_DOFF_00);
            end
        end else if (!idx && !mid_q) begin
            // Status dword of a single or last buffer.
            next_be    = `DSQ_BE_ALL;
            next_wdata = sdw_q;
            if (style16) begin
                next_addr = base_q + `DSQ_DOFF_04;
            end else if (style_burst) begin
                next_addr = base_q + `DSQ_DOFF_00;
            end else begin
                next_addr = base_q + `DSQ_DOFF_08;
            end
        end else if (style16) begin
            // Ownership byte rides on the top lane only.
            next_addr  = base_q + `DSQ_DOFF_00;
            next_be    = `DSQ_BE_BYTE;
            next_wdata = {sw_q[7:0], 24'h00_0000};
        end else begin
            next_addr  = base_q + `DSQ_DOFF_04;
            next_be    = `DSQ_BE_WORD;
            next_wdata = {sw_q, 16'h0000};
        end
        if (burst_q) begin
            next_addr[1:0] = 2'b00;
        end
    end

    assign last_idx = (idx == (write_q && mid_q ? 1'b0 : 1'b1));

    // ======================================================================
    // Bus master sequencer
    // ======================================================================
    // One request per ownership period keeps reads and writes apart, at the
    // cost of a fresh arbitration for every descriptor.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state     <= dsq_pkg::ST_IDLE;
            cmd_ready <= 1'b1;
            cmd_done  <= 1'b0;
            req_n     <= 1'b1;
            frame_n   <= 1'b1;
            irdy_n    <= 1'b1;
            ctl_oe    <= 1'b0;
            cbe_n     <= 4'h0;
            ad_out    <= 32'h0000_0000;
            ad_oe     <= 1'b0;
            style_q   <= `DSQ_RST_STYLE;
            burst_q   <= 1'b0;
            write_q   <= 1'b0;
            mid_q     <= 1'b0;
            base_q    <= 32'h0000_0000;
            sdw_q     <= 32'h0000_0000;
            sw_q      <= 16'h0000;
            idx       <= 1'b0;
            rd_a      <= 32'h0000_0000;
        end else begin
            cmd_done <= 1'b0;
            case (state)
                dsq_pkg::ST_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        req_n     <= 1'b0;
                        style_q   <= software_structure_style;
                        write_q   <= cmd_write;
                        mid_q     <= cmd_chain_mid;
                        base_q    <= cmd_base;
                        sdw_q     <= cmd_status_dword;
                        sw_q      <= cmd_status_word;
                        idx       <= 1'b0;
                        burst_q   <= (software_structure_style == `DSQ_STYLE_32_BURST) &&
                                     (cmd_write ? burst_write_enable
                                                : burst_read_enable);
                        state     <= dsq_pkg::ST_REQ;
                    end
                end
                dsq_pkg::ST_REQ, dsq_pkg::ST_GAP: begin
                    // Address phase; a gap cycle precedes each later single transfer.
                    if (state == dsq_pkg::ST_GAP || !gnt_s) begin
                        frame_n <= 1'b0;
                        ctl_oe  <= 1'b1;
                        ad_oe   <= 1'b1;
                        ad_out  <= next_addr;
                        cbe_n   <= write_q ? `DSQ_CMD_MEM_WRITE : `DSQ_CMD_MEM_READ;
                        state   <= dsq_pkg::ST_ADDR;
                    end
                end
                dsq_pkg::ST_ADDR: begin
                    cbe_n <= next_be;
                    if (write_q) begin
                        ad_out <= next_wdata;
                        state  <= dsq_pkg::ST_WAIT;
                    end else begin
                        ad_oe   <= 1'b0;
                        irdy_n  <= 1'b0;
                        frame_n <= last_idx || !burst_q;
                        state   <= dsq_pkg::ST_DATA;
                    end
                end
                dsq_pkg::ST_WAIT: begin
                    // The extra write clock ends here; data and lanes follow the index.
                    irdy_n  <= 1'b0;
                    ad_out  <= next_wdata;
                    cbe_n   <= next_be;
                    frame_n <= last_idx || !burst_q;
                    state   <= dsq_pkg::ST_DATA;
                end
                dsq_pkg::ST_DATA: begin
                    if (!trdy_s) begin
                        if (!write_q && !idx) begin
                            rd_a <= ad_s;
                        end
                        if (last_idx) begin
                            irdy_n <= 1'b1;
                            req_n  <= 1'b1;
                            state  <= dsq_pkg::ST_DONE;
                        end else if (burst_q) begin
                            idx   <= 1'b1;
                            if (write_q) begin
                                irdy_n <= 1'b1;
                                state  <= dsq_pkg::ST_WAIT;
                            end else begin
                                frame_n <= 1'b1;
                            end
                        end else begin
                            idx    <= 1'b1;
                            irdy_n <= 1'b1;
                            ad_oe  <= 1'b0;
                            state  <= dsq_pkg::ST_GAP;
                        end
                    end
                end
                dsq_pkg::ST_DONE: begin
                    ctl_oe    <= 1'b0;
                    ad_oe     <= 1'b0;
                    cmd_ready <= 1'b1;
                    cmd_done  <= 1'b1;
                    state     <= dsq_pkg::ST_IDLE;
                end
                default: begin
                    state <= dsq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Descriptor word assembly for reads
    // ======================================================================
    // Bytes that do not belong to a descriptor word are dropped as zero.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            descriptor_word_zero <= 32'h0000_0000;
            descriptor_word_one  <= 32'h0000_0000;
            descriptor_word_two  <= 32'h0000_0000;
        end else if (state == dsq_pkg::ST_DATA && !trdy_s && !write_q && idx) begin
            descriptor_word_two <= 32'h0000_0000;
            if (style16) begin
                descriptor_word_zero <= {8'h00, rd_a[23:0]};
                descriptor_word_one  <= {rd_a[31:24], 8'h00, ad_s[15:0]};
                descriptor_word_two  <= {16'h0000, ad_s[31:16]};
            end else if (style_burst) begin
                descriptor_word_one  <= rd_a;
                descriptor_word_zero <= ad_s;
            end else begin
                descriptor_word_zero <= rd_a;
                descriptor_word_one  <= ad_s;
            end
        end
    end

endmodule : descriptor_dma_sequencer

// >>> rtl/dsq_consts.svh
// Constants of the descriptor DMA sequencer.
`ifndef DSQ_CONSTS_SVH
`define DSQ_CONSTS_SVH

// ==========================================================================
// Register map (byte addresses)
// ==========================================================================
`define DSQ_OFF_STYLE        4'h0
`define DSQ_OFF_BURST        4'h4
`define DSQ_OFF_STATUS       4'h8

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define DSQ_BIT_BURST_READ   6
`define DSQ_BIT_BURST_WRITE  5
`define DSQ_RST_STYLE        8'h00
`define DSQ_RST_BURST_READ   1'b0
`define DSQ_RST_BURST_WRITE  1'b0

// ==========================================================================
// Software structure styles
// ==========================================================================
`define DSQ_STYLE_16         8'h00
`define DSQ_STYLE_32         8'h02
`define DSQ_STYLE_32_BURST   8'h03

// ==========================================================================
// Bus commands and active-low byte enables
// ==========================================================================
`define DSQ_CMD_MEM_READ     4'h6
`define DSQ_CMD_MEM_WRITE    4'h7
`define DSQ_BE_ALL           4'h0
`define DSQ_BE_BYTE          4'h7
`define DSQ_BE_WORD          4'h3

// ==========================================================================
// Descriptor offsets within one ring entry
// ==========================================================================
`define DSQ_DOFF_00          32'h0000_0000
`define DSQ_DOFF_04          32'h0000_0004
`define DSQ_DOFF_08          32'h0000_0008

// ==========================================================================
// AXI responses
// ==========================================================================
`define DSQ_RESP_OKAY        2'h0
`define DSQ_RESP_SLVERR      2'h2

`endif

// >>> rtl/dsq_pkg.sv
// Types shared by the descriptor DMA sequencer.
package dsq_pkg;

    // Sequencer states on the master bus.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ  = 3'b001,
        ST_ADDR = 3'b010,
        ST_WAIT = 3'b011,
        ST_DATA = 3'b100,
        ST_GAP  = 3'b101,
        ST_DONE = 3'b110
    } seq_state_e;

endpackage : dsq_pkg

// >>> rtl/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // ======================================================================
    // Per-bit synchronisers
    // ======================================================================
    // The first stage is read only by the second stage.
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    meta[i] <= 1'b1;
                    q[i]    <= 1'b1;
                end else begin
                    meta[i] <= d[i];
                    q[i]    <= meta[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

// >>> tb/descriptor_dma_sequencer_properties.sv
// Concurrent checks on the command port and master bus pins.
`timescale 1ns/10ps
`include "dsq_consts.svh"
module descriptor_dma_sequencer_properties (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic        cmd_write,
    input wire logic        cmd_chain_mid,
    input wire logic        cmd_done,
    input wire logic        req_n,
    input wire logic        frame_n,
    input wire logic        irdy_n,
    input wire logic        trdy_n,
    input wire logic        ctl_oe,
    input wire logic [3:0]  cbe_n,
    input wire logic [31:0] ad_out,
    input wire logic        ad_oe
);
    // ========================================
    // Data phase counter
    // Counts data transfers since the last take.
    int n;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            n <= 0;
        else if (cmd_valid && cmd_ready)
            n <= 0;
        else if (!irdy_n && !trdy_n)
            n <= n + 1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    chk_phase_count: assert property (cmd_done |-> n == ((cmd_write && cmd_chain_mid) ? 1 : 2))
        else $error("bad phase count");
    chk_one_direction: assert property ($fell(frame_n) |-> cbe_n == (cmd_write ?
        `DSQ_CMD_MEM_WRITE : `DSQ_CMD_MEM_READ)) else $error("wrong command");
    chk_read_lanes: assert property (!irdy_n && !cmd_write |-> cbe_n == `DSQ_BE_ALL)
        else $error("read lanes off");
    chk_write_lanes: assert property (!irdy_n && cmd_write |-> cbe_n != `DSQ_BE_ALL ||
        !cmd_chain_mid) else $error("chain write lanes");
    chk_write_wait: assert property ($fell(frame_n) && cmd_write |=> irdy_n && ad_oe ##1 !irdy_n)
        else $error("no write wait");
    chk_read_no_wait: assert property ($fell(frame_n) && !cmd_write |=> !irdy_n && !ad_oe)
        else $error("read phase late");
    chk_aligned_addr: assert property ($fell(frame_n) |-> ad_oe && ctl_oe && ad_out[1:0] == 2'h0)
        else $error("bad address phase");
    chk_idle_bus: assert property (cmd_ready |-> req_n && frame_n && irdy_n)
        else $error("bus active while idle");
    chk_done_pulse: assert property (cmd_done |=> !cmd_done && cmd_ready)
        else $error("done not a pulse");
endmodule : descriptor_dma_sequencer_properties

// >>> tb/pci_target_model.sv
// Bus target model holding a four-word descriptor ring memory.
`timescale 1ns/10ps
module pci_target_model (
    input  wire logic        mclk,
    input  wire logic [3:0]  slow,
    input  wire logic        req_n,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic [3:0]  cbe_n,
    input  wire logic [31:0] ad_out,
    input  wire logic        ad_oe,
    output logic             gnt_n = 1'h1,
    output logic             trdy_n = 1'h1,
    output logic [31:0]      ad_in
);
    // ========================================
    // Target behaviour
    logic [31:0] mem [0:3];
    logic [3:0]  addr = 4'h0;
    logic [3:0]  dly = 4'h0;
    logic        wr = 1'h0;
    logic        fp = 1'h1;
    logic        fin = 1'h1;
    int          naddr = 0;
    wire         go = !irdy_n && !fin && trdy_n && dly >= slow;
    // Outside ready the lines show the inverse, so stale data is caught.
    assign ad_in = trdy_n ? ~mem[addr[3:2]] : mem[addr[3:2]];
    // Ready is one clock per phase, as the master reacts late; a phase with frame high is last.
    always @(posedge mclk) begin
        gnt_n <= req_n;
        fp <= frame_n;
        trdy_n <= !go;
        if (irdy_n || fin || !trdy_n)
            dly <= 4'h0;
        else if (dly < slow)
            dly <= dly + 4'h1;
        if (go)
            fin <= frame_n;
        if (!trdy_n)
            addr <= addr + 4'h4;
        if (!irdy_n && !trdy_n && wr)
            for (int b = 0; b < 4; b++)
                if (!cbe_n[b])
                    mem[addr[3:2]][8*b +: 8] <= ad_out[8*b +: 8];
        if (fp && !frame_n && ad_oe) begin
            addr <= ad_out[3:0];
            wr <= cbe_n[0];
            fin <= 1'h0;
            naddr <= naddr + 1;
        end
    end
endmodule : pci_target_model

// >>> tb/descriptor_dma_sequencer_tb.sv
// Bench: settings over AXI4-Lite, descriptor reads and writes.
`timescale 1ns/10ps
`include "dsq_consts.svh"
module descriptor_dma_sequencer_tb;
    logic        mclk = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        cmd_valid = 1'h0, cmd_write = 1'h0, cmd_chain_mid = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, slow = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, q;
    logic [1:0]  r;
    logic [7:0]  st;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_ready;
    logic        cmd_done, req_n, gnt_n, frame_n, irdy_n, ctl_oe, trdy_n, ad_oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  cbe_n;
    logic [31:0] s_axi_rdata, descriptor_word_zero, descriptor_word_one, ad_out, ad_in;
    logic [31:0] descriptor_word_two;
    int          fail_count = 0, n_checks = 0, cyc = 0;
    descriptor_dma_sequencer u_descriptor_dma_sequencer (.mclk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid,
        .cmd_ready, .cmd_write, .cmd_chain_mid, .cmd_base(32'h0), .cmd_status_dword(32'h1234_5678),
        .cmd_status_word(16'h5A5A), .cmd_done, .descriptor_word_zero, .descriptor_word_one,
        .descriptor_word_two, .req_n, .gnt_n, .frame_n, .irdy_n, .ctl_oe, .trdy_n, .cbe_n,
        .ad_out, .ad_oe, .ad_in);
    pci_target_model u_tgt (.mclk, .slow, .req_n, .frame_n, .irdy_n, .cbe_n, .ad_out, .ad_oe,
        .gnt_n, .trdy_n, .ad_in);
    // ========================================
    // Clock, watchdog and shared tasks
    always #25 mclk = ~mclk;
    // A hung handshake would stall, so a ceiling forces a verdict.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    // One register access; each channel is released when taken.
    task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
        bit ta, tw;
        ta = 0;
        tw = !w;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        s_axi_bready <= w;
        s_axi_rready <= !w;
        while (!(ta && tw)) begin
            @(posedge mclk);
            if (!ta && (w ? s_axi_awready : s_axi_arready)) begin
                ta = 1;
                s_axi_awvalid <= 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (!tw && s_axi_wready) begin
                tw = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge mclk); while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'h1);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        q = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
    endtask : rw
    // One descriptor access on a fresh ring; counts address phases.
    task automatic op(input logic w, mid, input int np);
        int n0;
        for (int k = 0; k < 4; k++)
            u_tgt.mem[k] = 32'h1111_1111 * (k + 1);
        n0 = u_tgt.naddr;
        cmd_valid <= 1'h1;
        cmd_write <= w;
        cmd_chain_mid <= mid;
        do @(posedge mclk); while (cmd_ready !== 1'h1);
        cmd_valid <= 1'h0;
        do @(posedge mclk); while (cmd_done !== 1'h1);
        check("address phases", 32'(u_tgt.naddr - n0), 32'(np));
    endtask : op
    task automatic memchk(input int sk, ok);
        for (int k = 0; k < 4; k++)
            check("ring word", u_tgt.mem[k], k == sk ? 32'h1234_5678 : k != ok ?
                32'h1111_1111 * (k + 1) : st == 8'h00 ? 32'h5A11_1111 : 32'h5A5A_2222);
    endtask : memchk
    // ========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        rw(1'h0, `DSQ_OFF_BURST, 32'h0);
        check("burst reset", q, 32'h0);
        rw(1'h0, 4'hC, 32'h0);
        check("unmapped", 32'(r), 32'(`DSQ_RESP_SLVERR));
        for (int i = 0; i < 4; i++) begin
            st = i == 0 ? `DSQ_STYLE_16 : i == 1 ? `DSQ_STYLE_32 : `DSQ_STYLE_32_BURST;
            rw(1'h1, `DSQ_OFF_STYLE, {24'h0, st});
            rw(1'h1, `DSQ_OFF_BURST, i == 2 ? 32'h0 : 32'h60);
            rw(1'h0, `DSQ_OFF_BURST, 32'h0);
            check("burst setting", q & 32'h60, i == 2 ? 32'h0 : 32'h60);
            slow <= 4'(i);
            op(1'h0, 1'h0, i == 3 ? 1 : 2);
            check("word zero", descriptor_word_zero, i == 0 ? 32'h0011_1111 :
                i == 1 ? 32'h1111_1111 : 32'h3333_3333);
            check("word one", descriptor_word_one, i == 0 ? 32'h1100_2222 : 32'h2222_2222);
            check("word two", descriptor_word_two, i == 0 ? 32'h0000_2222 : 32'h0);
            op(1'h1, 1'h0, i == 3 ? 1 : 2);
            memchk(i == 0 ? 1 : i == 1 ? 2 : 0, i == 0 ? 0 : 1);
            op(1'h1, 1'h1, 1);
            memchk(-1, i == 0 ? 0 : 1);
            $display("Test style %0d done", st);
        end
        conclude();
    end
endmodule : descriptor_dma_sequencer_tb
bind descriptor_dma_sequencer descriptor_dma_sequencer_properties u_chk (.mclk, .rst, .cmd_valid,
    .cmd_ready, .cmd_write, .cmd_chain_mid, .cmd_done, .req_n, .frame_n, .irdy_n, .ctl_oe,
    .cbe_n, .ad_out, .ad_oe, .trdy_n);
